/* File: include/flash_blk_pkg.sv */
package flash_blk_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  // Longest quiet gap between two instruction bytes, rounded down to cycles.
  localparam int BYTE_TIMEOUT_NS = 80000;
  localparam int BYTE_TIMEOUT_CYC = BYTE_TIMEOUT_NS * 1000 / CLK_PERIOD_PS;
  // Least time of one word program, rounded up to cycles.
  localparam int PROG_TIME_NS = 10000;
  localparam int PROG_CYC = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 8;
  localparam int PRIM_SECTORS = 8;
  localparam int SEC_SECTORS = 4;
  localparam int PRIM_WORDS = 32768;
  localparam int SEC_WORDS = 4096;
  localparam int PRIM_IDX_W = 18;
  localparam int SEC_IDX_W = 14;
  localparam int WALK_W = 15;
  localparam int SEL_COUNT = 13;
  localparam int TERMS = 3;
  localparam int DEC_ADDR_LSB = 12;
  localparam int SRAM_SEL_IDX = 12;

  // ==========================================================================
  // Register offsets, fields and reset values
  // ==========================================================================
  localparam logic [7:0] REG_MEM_ID0 = 8'h00;
  localparam logic [7:0] REG_MEM_ID1 = 8'h01;
  localparam logic [7:0] REG_PRIM_PROT = 8'h02;
  localparam logic [7:0] REG_SEC_PROT = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h05;
  localparam logic [3:0] SRAM_SIZE_CODE = 4'h3;
  localparam logic [3:0] PRIM_SIZE_CODE = 4'h5;
  localparam logic [3:0] SEC_SIZE_CODE = 4'h2;
  localparam logic [1:0] SEC_TYPE_FLASH = 2'h0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SUSP = 1;
  localparam int STAT_ERR = 2;
  localparam int CTRL_RDYBSY = 0;
  localparam logic [7:0] PRIM_PROT_RST = 8'h00;
  localparam logic [3:0] SEC_PROT_RST = 4'h0;
  localparam logic CTRL_RDYBSY_RST = 1'b1;
  // Identification word returned in identify mode; the value is arbitrary.
  localparam logic [15:0] FLASH_ID_CODE = 16'h00c5;

  // ==========================================================================
  // Instruction bytes and addresses
  // ==========================================================================
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'haaa;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h554;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [11:0] ID_ADDR = 12'h002;
  localparam logic [11:0] PROT_ADDR = 12'h004;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_UNLOCK1 = 4'b0001,
    S_UNLOCK2 = 4'b0010,
    S_PROG_DATA = 4'b0011,
    S_ERASE_U0 = 4'b0100,
    S_ERASE_U1 = 4'b0101,
    S_ERASE_CMD = 4'b0110,
    S_IDENTIFY = 4'b0111,
    S_PROGRAM = 4'b1000,
    S_ERASING = 4'b1001,
    S_SUSPENDED = 4'b1010
  } seq_t;

  // ==========================================================================
  // Address decode map: one term compares address bits 19..12 under a mask
  // ==========================================================================
  typedef struct packed {
    logic en;
    logic [7:0] mask;
    logic [7:0] match;
  } term_t;
  typedef term_t [TERMS-1:0] sel_terms_t;
  typedef sel_terms_t [SEL_COUNT-1:0] decode_map_t;

  localparam logic [7:0] PRIM_TERM_MASK = 8'hf0;
  localparam logic [7:0] SEC_TERM_BASE = 8'h80;
  localparam logic [7:0] SEC_TERM_MASK = 8'hfe;
  localparam logic [7:0] SRAM_TERM_BASE = 8'h88;

  function automatic decode_map_t buildDefaultMap();
    decode_map_t m;
    m = '0;
    for (int s = 0; s < PRIM_SECTORS; s++)
    begin
      m[s][0] = '{en: 1'b1, mask: PRIM_TERM_MASK, match: 8'(s * 16)};
    end
    for (int j = 0; j < SEC_SECTORS; j++)
    begin
      m[PRIM_SECTORS + j][0] = '{en: 1'b1, mask: SEC_TERM_MASK, match: SEC_TERM_BASE + 8'(j * 2)};
    end
    m[SRAM_SEL_IDX][0] = '{en: 1'b1, mask: SEC_TERM_MASK, match: SRAM_TERM_BASE};
    return m;
  endfunction

  localparam decode_map_t DEFAULT_MAP = buildDefaultMap();

endpackage

/* File: include/decode_if.sv */
`timescale 1ns/1ps
interface decode_if;
  logic [19:0] addr;
  logic [7:0] primSel;
  logic [3:0] secSel;
  logic sramSel;
  modport dec (input addr, output primSel, output secSel, output sramSel);
  modport user (output addr, input primSel, input secSel, input sramSel);
endinterface

/* File: hdl/address_decode_logic.sv */
`timescale 1ns/1ps
module address_decode_logic #(
  parameter flash_blk_pkg::decode_map_t MAP = flash_blk_pkg::DEFAULT_MAP
) (
  decode_if.dec bus
);
  import flash_blk_pkg::*;

  logic [SEL_COUNT-1:0] hit;

  // ==========================================================================
  // Each select is the OR of its enabled product terms
  // ==========================================================================
  for (genvar s = 0; s < SEL_COUNT; s++)
  begin : g_sel
    logic [TERMS-1:0] termHit;
    for (genvar t = 0; t < TERMS; t++)
    begin : g_term
      assign termHit[t] = MAP[s][t].en &&
        ((bus.addr[ADDR_W-1:DEC_ADDR_LSB] & MAP[s][t].mask) == (MAP[s][t].match & MAP[s][t].mask));
    end
    assign hit[s] = |termHit;
  end

  assign bus.primSel = hit[PRIM_SECTORS-1:0];
  assign bus.secSel = hit[PRIM_SECTORS+SEC_SECTORS-1:PRIM_SECTORS];
  assign bus.sramSel = hit[SRAM_SEL_IDX];

endmodule

/* File: hdl/flash_memory_block_control.sv */
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Function
// RULE1: Report SRAM size as 4-bit code.
// RULE2: Secondary size code in identity bits 3..0.
// RULE3: Secondary type in bits 5..4, bit 6 zero.
// RULE4: Primary flash: eight 32-Kbyte sectors, eight selects. The code's sectors hold 32768 words, 64 Kbytes each.
// RULE5: Secondary flash: four sectors, four selects.
// RULE6: Protected sectors reject program and erase.
// RULE7: Erase per sector, program per word.
// RULE8: Sector erase can suspend and resume.
// RULE9: Selects are OR of three decoded terms.
// RULE10: Status pin low while program/erase busy.
// RULE11: Plain reads return stored array data.
// RULE12: Plain writes never store into flash.
// RULE13: Host polls status read or busy pin.
// RULE14: Identify sequence returns ID and protection.
// RULE15: Host sends two unlock writes first.
// RULE16: Bad byte or timeout returns read-array.
// RULE17: Route instruction by active select group.
// RULE18: Identification registers ignore host writes.
module flash_memory_block_control #(
  parameter int BYTE_TIMEOUT_P = flash_blk_pkg::BYTE_TIMEOUT_CYC
) (
  input logic clk,
  input logic rst,
  input logic [flash_blk_pkg::REG_AW-1:0] regAddr,
  input logic [7:0] regWrData,
  input logic regWr,
  input logic regRd,
  output logic [7:0] regRdData,
  input logic [flash_blk_pkg::ADDR_W-1:0] hostAddr,
  input logic [flash_blk_pkg::DATA_W-1:0] hostWrData,
  input logic hostWr,
  input logic hostRd,
  output logic [flash_blk_pkg::DATA_W-1:0] hostRdData,
  output logic flashStatusPin,
  output logic flashStatusPinOe
);
  import flash_blk_pkg::*;

  typedef struct packed {
    seq_t seq;
    logic target;
    logic [2:0] opSector;
    logic [PRIM_IDX_W-1:0] opIdx;
    logic [DATA_W-1:0] opData;
    logic [15:0] waitCnt;
    logic [15:0] timeoutCnt;
    logic [WALK_W-1:0] walkIdx;
    logic toggle;
    logic [DATA_W-1:0] rdData;
    logic [7:0] regRd;
    logic [7:0] primProt;
    logic [3:0] secProt;
    logic rdyBsyEn;
    logic err;
    logic pin;
    logic pinOe;
  } state_t;

  state_t q;
  state_t d;
  decode_if decBus();

  logic [DATA_W-1:0] primMem [0:PRIM_SECTORS*PRIM_WORDS-1];
  logic [DATA_W-1:0] secMem [0:SEC_SECTORS*SEC_WORDS-1];
  logic primWe;
  logic secWe;
  logic [PRIM_IDX_W-1:0] wrIdx;
  logic [DATA_W-1:0] wrData;
  logic wrIsErase;
  logic anyPrim;
  logic anySec;
  logic anyFlash;
  logic curFlash;
  logic sameFlash;
  logic [2:0] curSector;
  logic curProt;
  logic [PRIM_IDX_W-1:0] curIdx;
  logic [7:0] wrByte;
  logic [11:0] lowAddr;
  logic inSequence;
  logic [WALK_W-1:0] walkLast;
  logic errSet;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  assign decBus.addr = hostAddr;

  // RULE9: product-term decode
  address_decode_logic u_decode (
    .bus(decBus)
  );

  function automatic logic [2:0] lowestSel(input logic [7:0] sel);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = PRIM_SECTORS - 1; i >= 0; i--)
    begin
      if (sel[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  always_comb
  begin
    anyPrim = |decBus.primSel;
    anySec = |decBus.secSel;
    anyFlash = anyPrim || anySec;
    // RULE17: primary wins routing
    curFlash = !anyPrim;
    sameFlash = anyFlash && (curFlash == q.target);
    // RULE4: eight primary sectors
    // RULE5: four secondary sectors
    curSector = anyPrim ? lowestSel(decBus.primSel) : lowestSel({4'h0, decBus.secSel});
    curProt = anyPrim ? q.primProt[curSector] : q.secProt[curSector[1:0]];
    curIdx = anyPrim ? {curSector, hostAddr[15:1]} : PRIM_IDX_W'({curSector[1:0], hostAddr[12:1]});
    wrByte = hostWrData[7:0];
    lowAddr = hostAddr[11:0];
    inSequence = (q.seq == S_UNLOCK1) || (q.seq == S_UNLOCK2) || (q.seq == S_PROG_DATA) ||
                 (q.seq == S_ERASE_U0) || (q.seq == S_ERASE_U1) || (q.seq == S_ERASE_CMD);
    walkLast = q.target ? WALK_W'(SEC_WORDS - 1) : WALK_W'(PRIM_WORDS - 1);
  end

  // ==========================================================================
  // Sequencer, host read path and register file
  // ==========================================================================
  always_comb
  begin
    d = q;
    primWe = 1'b0;
    secWe = 1'b0;
    wrIdx = q.opIdx;
    wrData = q.opData;
    wrIsErase = 1'b0;
    errSet = 1'b0;

    if (inSequence)
    begin
      d.timeoutCnt = q.timeoutCnt + 16'h0001;
      // RULE16: inter-byte timeout
      if (q.timeoutCnt == 16'(BYTE_TIMEOUT_P - 1))
      begin
        d.seq = S_IDLE;
      end
    end

    if (hostWr)
    begin
      d.timeoutCnt = 16'h0000;
      // RULE12: writes only steer the sequencer
      case (q.seq)
        S_IDLE, S_IDENTIFY:
        begin
          // RULE15: first unlock write
          if (anyFlash && wrByte == UNLOCK_DATA1 && lowAddr == UNLOCK_ADDR1)
          begin
            d.seq = S_UNLOCK1;
            d.target = curFlash;
          end
          else if (q.seq == S_IDENTIFY && sameFlash && wrByte == CMD_RESET)
          begin
            d.seq = S_IDLE;
          end
        end
        S_UNLOCK1:
        begin
          // RULE16: wrong second unlock aborts
          d.seq = (sameFlash && wrByte == UNLOCK_DATA2 && lowAddr == UNLOCK_ADDR2) ? S_UNLOCK2 : S_IDLE;
        end
        S_UNLOCK2:
        begin
          d.seq = S_IDLE;
          if (sameFlash && lowAddr == UNLOCK_ADDR1)
          begin
            if (wrByte == CMD_PROGRAM)
            begin
              d.seq = S_PROG_DATA;
            end
            else if (wrByte == CMD_ERASE_SETUP)
            begin
              d.seq = S_ERASE_U0;
            end
            // RULE14: enter identify mode
            else if (wrByte == CMD_IDENTIFY)
            begin
              d.seq = S_IDENTIFY;
            end
          end
        end
        S_PROG_DATA:
        begin
          d.seq = S_IDLE;
          // RULE6: protected sector refuses program
          if (sameFlash && curProt)
          begin
            d.err = 1'b1;
            errSet = 1'b1;
          end
          // RULE7: one word per program
          else if (sameFlash)
          begin
            d.seq = S_PROGRAM;
            d.opIdx = curIdx;
            d.opData = hostWrData;
            d.waitCnt = 16'h0000;
          end
        end
        S_ERASE_U0:
        begin
          d.seq = (sameFlash && wrByte == UNLOCK_DATA1 && lowAddr == UNLOCK_ADDR1) ? S_ERASE_U1 : S_IDLE;
        end
        S_ERASE_U1:
        begin
          d.seq = (sameFlash && wrByte == UNLOCK_DATA2 && lowAddr == UNLOCK_ADDR2) ? S_ERASE_CMD : S_IDLE;
        end
        S_ERASE_CMD:
        begin
          d.seq = S_IDLE;
          if (sameFlash && wrByte == CMD_SECTOR_ERASE)
          begin
            // RULE6: protected sector refuses erase
            if (curProt)
            begin
              d.err = 1'b1;
              errSet = 1'b1;
            end
            else
            begin
              d.seq = S_ERASING;
              d.opSector = curSector;
              d.walkIdx = '0;
            end
          end
        end
        S_ERASING:
        begin
          // RULE8: suspend the erase
          if (sameFlash && wrByte == CMD_SUSPEND)
          begin
            d.seq = S_SUSPENDED;
          end
        end
        S_SUSPENDED:
        begin
          // RULE8: resume the erase
          if (sameFlash && wrByte == CMD_RESUME)
          begin
            d.seq = S_ERASING;
          end
        end
        default:
        begin
        end
      endcase
    end

    if (q.seq == S_PROGRAM)
    begin
      d.waitCnt = q.waitCnt + 16'h0001;
      if (q.waitCnt == 16'(PROG_CYC - 1))
      begin
        primWe = !q.target;
        secWe = q.target;
        d.seq = S_IDLE;
      end
    end

    // RULE7: erase walks one sector only
    if (q.seq == S_ERASING && d.seq == S_ERASING)
    begin
      primWe = !q.target;
      secWe = q.target;
      wrIsErase = 1'b1;
      wrData = ERASED_WORD;
      wrIdx = q.target ? PRIM_IDX_W'({q.opSector[1:0], q.walkIdx[11:0]}) : {q.opSector, q.walkIdx};
      d.walkIdx = q.walkIdx + WALK_W'(1);
      if (q.walkIdx == walkLast)
      begin
        d.seq = S_IDLE;
      end
    end

    d.rdData = '0;
    if (hostRd && anyFlash)
    begin
      // RULE13: status word while the busy flash is read
      if (sameFlash && (q.seq == S_PROGRAM || q.seq == S_ERASING))
      begin
        d.rdData = {8'h00, (q.seq == S_PROGRAM) ? ~q.opData[7] : 1'b0, q.toggle, 6'h00};
        d.toggle = !q.toggle;
      end
      // RULE14: identify reads
      else if (sameFlash && q.seq == S_IDENTIFY && lowAddr == ID_ADDR)
      begin
        d.rdData = FLASH_ID_CODE;
      end
      else if (sameFlash && q.seq == S_IDENTIFY && lowAddr == PROT_ADDR)
      begin
        d.rdData = {15'h0000, curProt};
      end
      // RULE11: read like a ROM
      else
      begin
        d.rdData = anyPrim ? primMem[curIdx] : secMem[curIdx[SEC_IDX_W-1:0]];
      end
    end

    // RULE18: identification offsets take no write
    if (regWr)
    begin
      if (regAddr == REG_PRIM_PROT)
      begin
        d.primProt = regWrData;
      end
      else if (regAddr == REG_SEC_PROT)
      begin
        d.secProt = regWrData[3:0];
      end
      else if (regAddr == REG_CTRL)
      begin
        d.rdyBsyEn = regWrData[CTRL_RDYBSY];
      end
      // A refusal in this same cycle keeps the error flag set.
      else if (regAddr == REG_STATUS && regWrData[STAT_ERR] && !errSet)
      begin
        d.err = 1'b0;
      end
    end

    d.regRd = 8'h00;
    if (regRd)
    begin
      // RULE1: SRAM size code
      if (regAddr == REG_MEM_ID0)
      begin
        d.regRd = {SRAM_SIZE_CODE, PRIM_SIZE_CODE};
      end
      // RULE2: secondary size code
      // RULE3: type field, bit 6 zero
      else if (regAddr == REG_MEM_ID1)
      begin
        d.regRd = {2'b00, SEC_TYPE_FLASH, SEC_SIZE_CODE};
      end
      else if (regAddr == REG_PRIM_PROT)
      begin
        d.regRd = q.primProt;
      end
      else if (regAddr == REG_SEC_PROT)
      begin
        d.regRd = {4'h0, q.secProt};
      end
      else if (regAddr == REG_STATUS)
      begin
        d.regRd = {5'h00, q.err, q.seq == S_SUSPENDED, (q.seq == S_PROGRAM || q.seq == S_ERASING)};
      end
      else if (regAddr == REG_CTRL)
      begin
        d.regRd = {7'h00, q.rdyBsyEn};
      end
    end

    // RULE10: ready/busy pin
    d.pin = !(d.seq == S_PROGRAM || d.seq == S_ERASING);
    d.pinOe = d.rdyBsyEn;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '{seq: S_IDLE, primProt: PRIM_PROT_RST, secProt: SEC_PROT_RST, rdyBsyEn: CTRL_RDYBSY_RST,
             pin: 1'b1, pinOe: CTRL_RDYBSY_RST, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // Program can only clear bits, so the new word is ANDed with the old one.
  always_ff @(posedge clk)
  begin
    if (primWe)
    begin
      primMem[wrIdx] <= wrIsErase ? wrData : (primMem[wrIdx] & wrData);
    end
    if (secWe)
    begin
      secMem[wrIdx[SEC_IDX_W-1:0]] <= wrIsErase ? wrData : (secMem[wrIdx[SEC_IDX_W-1:0]] & wrData);
    end
  end

  assign regRdData = q.regRd;
  assign hostRdData = q.rdData;
  assign flashStatusPin = q.pin;
  assign flashStatusPinOe = q.pinOe;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  id0_read_a: assert property (regRd && regAddr == REG_MEM_ID0 |=> regRdData == 8'h35) else $error("bad id0"); // RULE1
  id1_read_a: assert property (regRd && regAddr == REG_MEM_ID1 |=> regRdData == 8'h02) else $error("bad id1"); // RULE2
  id1_type_a: assert property (regRd && regAddr == REG_MEM_ID1 // RULE3
    |=> regRdData[6] == 1'b0 && regRdData[5:4] == SEC_TYPE_FLASH) else $error("id1 type field wrong");
  busy_pin_a: assert property ($rose(q.seq == S_PROGRAM) |-> !flashStatusPin ##1 !flashStatusPin) // RULE10
    else $error("pin not busy");
  protect_a: assert property (q.seq == S_PROG_DATA && hostWr && sameFlash && curProt // RULE6
    |=> q.seq == S_IDLE && q.err && flashStatusPin) else $error("protected sector programmed");
  err_set_wins_a: assert property (regWr && regAddr == REG_STATUS && regWrData[STAT_ERR] && errSet // RULE6
    |=> q.err) else $error("new refusal lost to clear");
  plain_write_a: assert property ((primWe || secWe) |-> q.seq == S_PROGRAM || q.seq == S_ERASING) // RULE12
    else $error("array written outside operation");
  suspend_a: assert property (q.seq == S_ERASING && hostWr && sameFlash && wrByte == CMD_SUSPEND // RULE8
    |=> q.seq == S_SUSPENDED && $stable(q.walkIdx) ##1 !(primWe || secWe)) else $error("suspend failed");
  timeout_a: assert property (inSequence && !hostWr && q.timeoutCnt == 16'(BYTE_TIMEOUT_P - 1) // RULE16
    |=> q.seq == S_IDLE) else $error("timeout ignored");
  prog_time_a: assert property (q.seq == S_PROGRAM |-> q.waitCnt < 16'(PROG_CYC)) else $error("program too long"); // RULE7
  identify_a: assert property (q.seq == S_IDENTIFY && hostRd && sameFlash && lowAddr == ID_ADDR // RULE14
    |=> hostRdData == FLASH_ID_CODE) else $error("bad identify read");

  program_done_c: cover property (q.seq == S_PROGRAM ##1 q.seq == S_IDLE);
  erase_resume_c: cover property (q.seq == S_SUSPENDED ##1 q.seq == S_ERASING);
  identify_c: cover property (q.seq == S_IDENTIFY && hostRd);

endmodule

/* File: test/mcu_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Microcontroller side of the host flash bus
module mcu_host_model (
  input logic clk,
  output logic [19:0] hostAddr,
  output logic [15:0] hostWrData,
  output logic hostWr,
  output logic hostRd,
  input logic [15:0] hostRdData
);
  import flash_blk_pkg::*;

  initial
  begin
    hostAddr = 20'h00000;
    hostWrData = 16'h0000;
    hostWr = 1'b0;
    hostRd = 1'b0;
  end

  task automatic busWrite(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk);
    hostAddr <= a;
    hostWrData <= d;
    hostWr <= 1'b1;
    @(posedge clk);
    hostWr <= 1'b0;
    // Released data lines change, so a stale value can never look valid.
    hostWrData <= ~d;
  endtask

  task automatic busRead(input logic [19:0] a, output logic [15:0] d);
    @(posedge clk);
    hostAddr <= a;
    hostRd <= 1'b1;
    @(posedge clk);
    hostRd <= 1'b0;
    #1 d = hostRdData;
  endtask

  task automatic unlock(input logic [19:0] base);
    busWrite({base[19:12], UNLOCK_ADDR1}, {8'h00, UNLOCK_DATA1});
    busWrite({base[19:12], UNLOCK_ADDR2}, {8'h00, UNLOCK_DATA2});
  endtask

  task automatic command(input logic [19:0] base, input logic [7:0] c);
    unlock(base);
    busWrite({base[19:12], UNLOCK_ADDR1}, {8'h00, c});
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import flash_blk_pkg::*;
  localparam int TMO = 20;
  localparam logic [19:0] SB = 20'h80000;
  localparam logic [19:0] PB = 20'h10000;
  logic clk;
  logic rst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic [19:0] hostAddr;
  logic [15:0] hostWrData;
  logic hostWr;
  logic hostRd;
  logic [15:0] hostRdData;
  logic flashStatusPin;
  logic flashStatusPinOe;
  logic [15:0] d;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  flash_memory_block_control #(.BYTE_TIMEOUT_P(TMO)) u_flash_memory_block_control (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd),
    .hostRdData(hostRdData), .flashStatusPin(flashStatusPin), .flashStatusPinOe(flashStatusPinOe));
  mcu_host_model u_mcu_host_model (.clk(clk), .hostAddr(hostAddr), .hostWrData(hostWrData),
    .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData));

  // ==========================================
  // Clock, timeout and reporting
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The whole run needs about 6300 cycles; the ceiling leaves ample margin.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(name, {8'h00, regRdData}, {8'h00, exp});
  endtask

  task automatic waitPin(input logic v, input int lim, input string name);
    int n;
    n = 0;
    // Look only once the updates of the launching edge have settled.
    #1;
    while (flashStatusPin !== v && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(name, {15'h0000, flashStatusPin}, {15'h0000, v});
  endtask

  task automatic readWord(input logic [19:0] a, input logic [15:0] exp, input string name);
    u_mcu_host_model.busRead(a, d);
    check(name, d, exp);
  endtask

  // ==========================================
  // Scenarios
  task automatic idScenario();
    regRead(REG_MEM_ID0, {SRAM_SIZE_CODE, PRIM_SIZE_CODE}, "id0");
    regRead(REG_MEM_ID1, {2'b00, SEC_TYPE_FLASH, SEC_SIZE_CODE}, "id1");
    regWrite(REG_MEM_ID0, 8'hff);
    regWrite(REG_MEM_ID1, 8'hff);
    regRead(REG_MEM_ID0, {SRAM_SIZE_CODE, PRIM_SIZE_CODE}, "id0 kept");
    regRead(REG_MEM_ID1, {2'b00, SEC_TYPE_FLASH, SEC_SIZE_CODE}, "id1 kept");
    regRead(8'hff, 8'h00, "unmapped");
    check("oe", {15'h0000, flashStatusPinOe}, 16'h0001);
    regWrite(REG_CTRL, 8'h00);
    #1 check("oe off", {15'h0000, flashStatusPinOe}, 16'h0000);
    regWrite(REG_CTRL, 8'h01);
  endtask

  task automatic eraseScenario();
    u_mcu_host_model.command(SB, CMD_ERASE_SETUP);
    u_mcu_host_model.unlock(SB);
    u_mcu_host_model.busWrite(SB, {8'h00, CMD_SECTOR_ERASE});
    waitPin(1'b0, 4, "erase busy");
    repeat (100) @(posedge clk);
    u_mcu_host_model.busWrite(SB, {8'h00, CMD_SUSPEND});
    waitPin(1'b1, 8, "suspended ready");
    regRead(REG_STATUS, 8'h02, "suspend flag");
    u_mcu_host_model.busWrite(SB, {8'h00, CMD_RESUME});
    waitPin(1'b0, 8, "resumed busy");
    waitPin(1'b1, 5000, "erase done");
    readWord(SB, ERASED_WORD, "erased first");
    readWord(SB | 20'h01ffe, ERASED_WORD, "erased last");
  endtask

  task automatic programScenario();
    u_mcu_host_model.command(SB, CMD_PROGRAM);
    u_mcu_host_model.busWrite(SB | 20'h00010, 16'h5a3c);
    waitPin(1'b0, 4, "prog busy");
    readWord(SB | 20'h00010, 16'h0080, "status poll");
    readWord(SB | 20'h00010, 16'h00c0, "status toggle");
    waitPin(1'b1, 2100, "prog done");
    readWord(SB | 20'h00010, 16'h5a3c, "programmed");
    readWord(SB | 20'h00012, ERASED_WORD, "neighbour");
    u_mcu_host_model.busWrite(SB | 20'h00020, 16'h0000);
    readWord(SB | 20'h00020, ERASED_WORD, "plain write");
    u_mcu_host_model.busWrite({SB[19:12], UNLOCK_ADDR1}, 16'h00aa);
    repeat (TMO + 5) @(posedge clk);
    u_mcu_host_model.busWrite({SB[19:12], UNLOCK_ADDR2}, 16'h0055);
    u_mcu_host_model.busWrite({SB[19:12], UNLOCK_ADDR1}, {8'h00, CMD_PROGRAM});
    u_mcu_host_model.busWrite(SB | 20'h00020, 16'h0000);
    waitPin(1'b1, 4, "timeout idle");
    readWord(SB | 20'h00020, ERASED_WORD, "timeout");
  endtask

  task automatic protectScenario();
    regWrite(REG_SEC_PROT, 8'h01);
    regRead(REG_SEC_PROT, 8'h01, "prot rw");
    u_mcu_host_model.command(SB, CMD_PROGRAM);
    u_mcu_host_model.busWrite(SB | 20'h00030, 16'h0000);
    waitPin(1'b1, 4, "prot ready");
    readWord(SB | 20'h00030, ERASED_WORD, "prot word");
    regRead(REG_STATUS, 8'h04, "err set");
    regWrite(REG_STATUS, 8'h04);
    regRead(REG_STATUS, 8'h00, "err clear");
    u_mcu_host_model.command(SB, CMD_IDENTIFY);
    readWord({SB[19:12], ID_ADDR}, FLASH_ID_CODE, "ident");
    u_mcu_host_model.busRead({SB[19:12], PROT_ADDR}, d);
    check("prot status", d, 16'h0001);
    u_mcu_host_model.busWrite(SB, {8'h00, CMD_RESET});
    readWord(SB | 20'h00010, 16'h5a3c, "read array");
  endtask

  task automatic primaryScenario();
    regWrite(REG_PRIM_PROT, 8'h02);
    regRead(REG_PRIM_PROT, 8'h02, "pprot rw");
    u_mcu_host_model.busWrite({PB[19:12], UNLOCK_ADDR1}, {8'h00, UNLOCK_DATA1});
    u_mcu_host_model.busWrite({SB[19:12], UNLOCK_ADDR2}, {8'h00, UNLOCK_DATA2});
    u_mcu_host_model.busWrite({PB[19:12], UNLOCK_ADDR1}, {8'h00, CMD_PROGRAM});
    u_mcu_host_model.busWrite(PB | 20'h00010, 16'h0000);
    regRead(REG_STATUS, 8'h00, "mixed group");
    u_mcu_host_model.command(PB, CMD_PROGRAM);
    u_mcu_host_model.busWrite(PB | 20'h00010, 16'h0000);
    regRead(REG_STATUS, 8'h04, "pprot err");
    u_mcu_host_model.command(PB, CMD_IDENTIFY);
    u_mcu_host_model.busRead({PB[19:12], PROT_ADDR}, d);
    check("pprot status", d, 16'h0001);
    readWord({PB[19:12], ID_ADDR}, FLASH_ID_CODE, "pident");
    u_mcu_host_model.busWrite(PB, {8'h00, CMD_RESET});
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    idScenario();
    eraseScenario();
    programScenario();
    protectScenario();
    primaryScenario();
    complete_run();
  end
endmodule
